// ### core/rss_reset_sequencer.sv
// reset source sequencer: supply, pin and watchdog resets, time-outs, cause flags
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "rss_defs.svh"
module rss_reset_sequencer #(
	parameter int BOR_MIN_NS = `RSS_BOR_MIN_NS
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// supply monitors and reset sources
	input  wire logic        por_pulse,
	input  wire logic        vdd_below_bor,
	input  wire logic        watchdog_timeout,
	input  wire logic        sleep_active,
	// clear pin, two-way
	input  wire logic        ext_clear_pin_in,
	output logic             ext_clear_pin_out,
	output logic             ext_clear_pin_oe,
	output logic             ext_clear_pull_up_en,
	// oscillator ticks
	input  wire logic        lfosc_tick,
	input  wire logic        osc_tick,
	// reset and clock control
	output logic             core_hold,
	output logic             reg_reset,
	output logic             int_osc_run,
	output logic             brownout_det_en,
	output logic             brownout_level_sel
);
	import rss_pkg::*;

	localparam int          BOR_CYC_I = (BOR_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS;
	localparam logic [16:0] BOR_CYC   = 17'(BOR_CYC_I);
	localparam logic [10:0] POWERUP_DELAY_TIMER_LAST = 11'(`RSS_POWERUP_DELAY_TIMER_MS * `RSS_LFOSC_KHZ - 1);
	localparam logic [9:0]  OST_LAST  = 10'(`RSS_OST_CYCLES - 1);
	localparam logic [7:0]  FLT_CYC   =
		8'((`RSS_CLR_FLT_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS);

	rss_state_t r;
	rss_state_t n;

	logic       bor_en;
	logic       bor_evt;
	logic       clr_evt;
	logic       crystal;
	logic       fast_run;
	logic       wr_acc;
	logic       rd_acc;
	logic [9:0] idx;
	logic [1:0] bmode;

	//--------------------------------------------------------------
	// next state
	//--------------------------------------------------------------
	always_comb begin
		n        = r;
		idx      = paddr[11:2];
		bmode    = r.cfg[`RSS_CFG_BMOD_LSB +: 2];
		crystal  = r.cfg[`RSS_CFG_OSC_LSB +: 3] <= `RSS_OSC_XTAL_MAX;
		fast_run = r.cfg[`RSS_CFG_TSPD_BIT] | r.cfg[`RSS_CFG_FSCM_BIT];
		wr_acc   = psel & penable & r.pready & pwrite;
		rd_acc   = psel & penable & ~r.pready;
		bor_en   = 1'b0;
		bor_evt  = 1'b0;
		clr_evt  = 1'b0;
		n.reg_reset = 1'b0;

		// brown-out detector enable by mode
		case (bmode)
			2'h0: bor_en = 1'b0;
			2'h1: bor_en = r.brownout_sw_enable;
			2'h2: bor_en = ~sleep_active;
			2'h3: bor_en = 1'b1;
			default: bor_en = 1'b0;
		endcase

		// brown-out must persist for the minimum duration
		if (bor_en && vdd_below_bor) begin
			if (r.bor_cnt != BOR_CYC) begin
				n.bor_cnt = r.bor_cnt + 17'h00001;
			end
			bor_evt = (r.bor_cnt == BOR_CYC - 17'h00001);
		end else begin
			n.bor_cnt = 17'h00000;
		end

		// clear pin glitch filter; disabled pin reads released
		if ((r.cfg[`RSS_CFG_CLRE_BIT] & ~ext_clear_pin_in) != r.pin_low) begin
			n.flt_cnt = r.flt_cnt + 8'h01;
			if (r.flt_cnt == FLT_CYC - 8'h01) begin
				n.pin_low = ~r.pin_low;
				n.flt_cnt = 8'h00;
				clr_evt   = ~r.pin_low;
			end
		end else begin
			n.flt_cnt = 8'h00;
		end

		//--------------------------------------------------------------
		// register access; hardware clears below take priority
		//--------------------------------------------------------------
		n.pready  = rd_acc;
		n.pslverr = 1'b0;
		if (rd_acc) begin
			case (idx)
				`RSS_POWER_RESET_CAUSE_IDX: n.prdata = {27'h0000000, r.brownout_sw_enable, 2'h0, r.por_n, r.bor_n};
				`RSS_CFG_IDX:  n.prdata = {22'h000000, r.cfg};
				`RSS_STAT_IDX: n.prdata = {24'h000000, r.core_hold, r.cause, r.st,
					r.pd_f, r.to_f};
				default: begin
					n.prdata  = 32'h00000000;
					n.pslverr = 1'b1;
				end
			endcase
		end
		if (wr_acc && idx == `RSS_POWER_RESET_CAUSE_IDX) begin
			n.bor_n  = pwdata[`RSS_POWER_RESET_CAUSE_BOR_BIT];
			n.por_n  = pwdata[`RSS_POWER_RESET_CAUSE_POR_BIT];
			n.brownout_sw_enable = pwdata[`RSS_POWER_RESET_CAUSE_SBE_BIT];
		end
		if (wr_acc && idx == `RSS_CFG_IDX) begin
			n.cfg = pwdata[9:0];
		end

		//--------------------------------------------------------------
		// sequencer
		//--------------------------------------------------------------
		case (r.st)
			st_hold: begin
				// wait for supply above threshold
				if (!vdd_below_bor) begin
					n.powerup_delay_timer_cnt = 11'h000;
					n.ost_cnt  = 10'h000;
					if (r.cold && !r.cfg[`RSS_CFG_PDLY_BIT]) begin
						n.st = st_powerup_delay_timer;
					end else if (r.cold && crystal) begin
						n.st = st_ost;
					end else begin
						n.st = st_run;
					end
				end
			end
			st_powerup_delay_timer: begin
				if (bor_en && vdd_below_bor) begin
					n.st       = st_hold;
					n.powerup_delay_timer_cnt = 11'h000;
				end else if (lfosc_tick) begin
					n.powerup_delay_timer_cnt = r.powerup_delay_timer_cnt + 11'h001;
					if (r.powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_LAST) begin
						n.st = crystal ? st_ost : st_run;
					end
				end
			end
			st_ost: begin
				if (osc_tick) begin
					n.ost_cnt = r.ost_cnt + 10'h001;
					if (r.ost_cnt == OST_LAST) begin
						n.st = st_run;
					end
				end
			end
			st_run: begin
				if (clr_evt) begin
					n.st        = st_hold;
					n.cold      = 1'b0;
					n.reg_reset = 1'b1;
					if (sleep_active) begin
						n.cause = cause_clr_sleep;
						n.pd_f  = 1'b0;
						n.to_f  = 1'b1;
					end else begin
						n.cause = cause_clr_run;
					end
				end else if (watchdog_timeout && !sleep_active) begin
					// internal only, pin untouched
					n.st        = st_hold;
					n.cold      = 1'b0;
					n.reg_reset = 1'b1;
					n.cause     = cause_wdt_run;
					n.to_f      = 1'b0;
				end else if (watchdog_timeout) begin
					// wake resumes, registers untouched
					n.cause   = cause_wdt_wake;
					n.to_f    = 1'b0;
					n.pd_f    = 1'b0;
					n.ost_cnt = 10'h000;
					n.st      = crystal ? st_ost : st_run;
				end
			end
			default: n.st = st_hold;
		endcase

		// supply resets override everything else
		if (bor_evt) begin
			n.st        = st_hold;
			n.cold      = 1'b1;
			n.reg_reset = 1'b1;
			n.bor_n     = 1'b0;
			n.to_f      = 1'b1;
			n.pd_f      = 1'b1;
			n.cause     = cause_bor;
		end
		if (por_pulse) begin
			n.st        = st_hold;
			n.cold      = 1'b1;
			n.reg_reset = 1'b1;
			n.por_n     = 1'b0;
			n.to_f      = 1'b1;
			n.pd_f      = 1'b1;
			n.cause     = cause_por;
		end

		//--------------------------------------------------------------
		// outputs
		//--------------------------------------------------------------
		n.core_hold   = (n.st == st_hold) || (n.st == st_powerup_delay_timer) ||
			(n.st == st_ost && !fast_run) || n.pin_low;
		n.int_osc_run = (n.st == st_ost) && fast_run;
		n.pull_up_en  = n.cfg[`RSS_CFG_CLRE_BIT];
		n.pin_oe      = 1'b1;
		n.bor_det_en  = bor_en;
		n.bor_lvl     = n.cfg[`RSS_CFG_BLVL_BIT];
	end

	//--------------------------------------------------------------
	// state register
	//--------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r             <= '0;
			r.st          <= st_hold;
			r.cold        <= 1'b1;
			r.brownout_sw_enable      <= 1'(`RSS_POWER_RESET_CAUSE_RST >> `RSS_POWER_RESET_CAUSE_SBE_BIT);
			r.bor_n       <= 1'b0;
			r.por_n       <= 1'b0;
			r.cfg         <= `RSS_CFG_RST;
			r.to_f        <= 1'b1;
			r.pd_f        <= 1'b1;
			r.cause       <= cause_por;
			r.core_hold   <= 1'b1;
			r.reg_reset   <= 1'b1;
			r.pull_up_en  <= 1'b1;
			r.pin_oe      <= 1'b1;
			r.bor_det_en  <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign prdata               = r.prdata;
	assign pready               = r.pready;
	assign pslverr              = r.pslverr;
	assign ext_clear_pin_out    = 1'b0;
	assign ext_clear_pin_oe     = r.pin_oe;
	assign ext_clear_pull_up_en = r.pull_up_en;
	assign core_hold            = r.core_hold;
	assign reg_reset            = r.reg_reset;
	assign int_osc_run          = r.int_osc_run;
	assign brownout_det_en      = r.bor_det_en;
	assign brownout_level_sel   = r.bor_lvl;

endmodule : rss_reset_sequencer

// ### core/rss_defs.svh
// offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// register word indices; byte address is four times the index
`define RSS_POWER_RESET_CAUSE_IDX     10'h08E
`define RSS_CFG_IDX      10'h090
`define RSS_STAT_IDX     10'h091

// power reset cause register fields
`define RSS_POWER_RESET_CAUSE_BOR_BIT 0
`define RSS_POWER_RESET_CAUSE_POR_BIT 1
`define RSS_POWER_RESET_CAUSE_SBE_BIT 4
`define RSS_POWER_RESET_CAUSE_RST     8'h10

// configuration register fields
`define RSS_CFG_CLRE_BIT 0
`define RSS_CFG_PDLY_BIT 1
`define RSS_CFG_BMOD_LSB 2
`define RSS_CFG_BLVL_BIT 4
`define RSS_CFG_OSC_LSB  5
`define RSS_CFG_TSPD_BIT 8
`define RSS_CFG_FSCM_BIT 9
`define RSS_CFG_RST      10'h0E1

// oscillator mode codes; codes up to the high speed crystal are crystals
`define RSS_OSC_EC       3'h3
`define RSS_OSC_XTAL_MAX 3'h2

// timing
`define RSS_CLK_NS       10
`define RSS_POWERUP_DELAY_TIMER_MS      64
`define RSS_LFOSC_KHZ    31
`define RSS_OST_CYCLES   1024
`define RSS_CLR_FLT_NS   2000
`define RSS_BOR_MIN_NS   100000

`endif

// ### core/rss_pkg.sv
// types of the reset sequencer
package rss_pkg;

	typedef enum logic [1:0] {
		st_hold,
		st_powerup_delay_timer,
		st_ost,
		st_run
	} rss_seq_t;

	typedef enum logic [2:0] {
		cause_por,
		cause_bor,
		cause_wdt_run,
		cause_wdt_wake,
		cause_clr_run,
		cause_clr_sleep
	} rss_cause_t;

	typedef struct packed {
		rss_seq_t   st;
		logic       cold;
		logic [7:0] flt_cnt;
		logic       pin_low;
		logic [16:0] bor_cnt;
		logic [10:0] powerup_delay_timer_cnt;
		logic [9:0] ost_cnt;
		logic       bor_n;
		logic       por_n;
		logic       brownout_sw_enable;
		logic [9:0] cfg;
		logic       to_f;
		logic       pd_f;
		rss_cause_t cause;
		logic [31:0] prdata;
		logic       pready;
		logic       pslverr;
		logic       core_hold;
		logic       reg_reset;
		logic       pull_up_en;
		logic       pin_oe;
		logic       int_osc_run;
		logic       bor_det_en;
		logic       bor_lvl;
	} rss_state_t;

endpackage : rss_pkg

// ### bench/rss_sva.sv
// port assertions of the reset source sequencer
`timescale 1ns/1ps
module rss_sva #(
	parameter int BOR_MIN_NS = 100
) (
	// clock, reset, apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// sources and controls
	input wire logic        por_pulse,
	input wire logic        vdd_below_bor,
	input wire logic        watchdog_timeout,
	input wire logic        sleep_active,
	input wire logic        ext_clear_pin_out,
	input wire logic        ext_clear_pin_oe,
	input wire logic        ext_clear_pull_up_en,
	input wire logic        core_hold,
	input wire logic        reg_reset,
	input wire logic        brownout_det_en,
	input wire logic        brownout_level_sel
);
	localparam int BOR_CYC = BOR_MIN_NS / 10;
	logic        cfg_wr;
	logic [4:0]  wr_r;
	logic [15:0] low_r;
	assign cfg_wr = psel && penable && pready && pwrite && paddr == 12'h240;
	// last cfg write and length of the current supply dip
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_r  <= 5'h00;
			low_r <= 16'h0000;
		end else begin
			wr_r  <= cfg_wr ? pwdata[4:0] : wr_r;
			low_r <= !(vdd_below_bor && brownout_det_en) ? 16'h0000 :
				(low_r == 16'(BOR_CYC)) ? low_r : low_r + 16'h0001;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_quiet;
		!core_hold && !por_pulse && !vdd_below_bor;
	endsequence
	sequence s_wdt_run;
		watchdog_timeout && !sleep_active ##0 s_quiet;
	endsequence
	sequence s_wdt_wake;
		watchdog_timeout && sleep_active ##0 s_quiet;
	endsequence
	AST_PIN_NEVER_DRIVEN: assert property (ext_clear_pin_oe && !ext_clear_pin_out)
		else $error("clear pin driven");
	AST_CFG_PULLUP: assert property (cfg_wr |-> ##2 ext_clear_pull_up_en == wr_r[0])
		else $error("pull-up not per cfg");
	AST_CFG_LEVEL: assert property (cfg_wr |-> ##2 brownout_level_sel == wr_r[4])
		else $error("level select not per cfg");
	AST_POR_HOLD: assert property ($rose(por_pulse) |=> core_hold && reg_reset)
		else $error("power-on not held");
	AST_LOAD_HOLDS: assert property (reg_reset |-> core_hold)
		else $error("load without hold");
	AST_WDT_RUN: assert property (s_wdt_run |=> core_hold && reg_reset)
		else $error("watchdog reset missing");
	AST_WDT_WAKE: assert property (s_wdt_wake |=> !reg_reset)
		else $error("wake loaded registers");
	AST_BOR_TRIP: assert property (low_r == 16'(BOR_CYC) |-> ##[0:4] core_hold)
		else $error("brown-out not held");
endmodule : rss_sva

bind rss_reset_sequencer rss_sva #(.BOR_MIN_NS(BOR_MIN_NS)) u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .por_pulse(por_pulse),
	.vdd_below_bor(vdd_below_bor), .watchdog_timeout(watchdog_timeout),
	.sleep_active(sleep_active), .ext_clear_pin_out(ext_clear_pin_out),
	.ext_clear_pin_oe(ext_clear_pin_oe), .ext_clear_pull_up_en(ext_clear_pull_up_en),
	.core_hold(core_hold), .reg_reset(reg_reset), .brownout_det_en(brownout_det_en),
	.brownout_level_sel(brownout_level_sel)
);

// ### bench/rss_partner.sv
// far side model: oscillator ticks and the clear pin wire
`timescale 1ns/1ps
module rss_partner (
	// clock and bench command
	input  wire logic pclk,
	input  wire logic hold_low,
	// clear pin
	input  wire logic pin_out,
	input  wire logic pin_oe,
	input  wire logic pull_up_en,
	output logic      pin_in,
	// oscillator ticks
	output logic      lfosc_tick,
	output logic      osc_tick
);
	logic tog_r = 1'b0;
	always @(posedge pclk) tog_r <= !tog_r;
	assign lfosc_tick = tog_r;
	assign osc_tick   = 1'b1;
	// undriven without pull-up: level flips every cycle
	assign pin_in = !pin_oe ? pin_out : hold_low ? 1'b0 : pull_up_en ? 1'b1 : tog_r;
endmodule : rss_partner

// ### bench/reset_source_sequencer_tb.sv
// bench of the reset source sequencer
`timescale 1ns/1ps
module reset_source_sequencer_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, se, pin_in, pin_out, pin_oe, pull_up, lf, os;
	logic        por = 1'b0;
	logic        vlow = 1'b0;
	logic        wdt = 1'b0;
	logic        slp = 1'b0;
	logic        hold = 1'b0;
	logic        core_hold, reg_reset, det_en, lvl;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          n_load = 0;
	int          n0, cyc;
	rss_reset_sequencer #(.BOR_MIN_NS(100)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.por_pulse(por), .vdd_below_bor(vlow), .watchdog_timeout(wdt), .sleep_active(slp),
		.ext_clear_pin_in(pin_in), .ext_clear_pin_out(pin_out), .ext_clear_pin_oe(pin_oe),
		.ext_clear_pull_up_en(pull_up), .lfosc_tick(lf), .osc_tick(os),
		.core_hold(core_hold), .reg_reset(reg_reset), .int_osc_run(),
		.brownout_det_en(det_en), .brownout_level_sel(lvl)
	);
	rss_partner u_far (
		.pclk(pclk), .hold_low(hold), .pin_out(pin_out), .pin_oe(pin_oe),
		.pull_up_en(pull_up), .pin_in(pin_in), .lfosc_tick(lf), .osc_tick(os)
	);
	initial begin
		forever #5 pclk = !pclk;
	end
	always @(negedge pclk) begin
		if (presetn && reg_reset) n_load++;
	end
	task automatic tally_and_finish();
		if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_run(input int lim);
		cyc = 0;
		while (core_hold !== 1'b0) begin
			@(posedge pclk);
			cyc++;
			if (cyc > lim) begin
				n_mismatch++;
				tally_and_finish();
			end
		end
	endtask : wait_run
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i == 20) begin
			n_mismatch++;
			tally_and_finish();
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		wait_run(4100);
		apb(1'b0, 12'h240, 32'h0);
		check(rd, 32'h0E1);
		check({pull_up, lvl}, 2'b10);
		apb(1'b0, 12'h238, 32'h0);
		check(rd, 32'h10);
		apb(1'b0, 12'h244, 32'h0);
		check(rd & 32'h73, 32'h03);
		apb(1'b0, 12'h000, 32'h0);
		check({31'h0, se}, 32'h1);
		check(rd, 32'h0);
		apb(1'b1, 12'h238, 32'h03);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 12'h240, 32'h30 | (m << 2));
			repeat (3) @(posedge pclk);
			check({det_en, pull_up}, {m > 1, 1'b0});
		end
		apb(1'b1, 12'h240, 32'h38);
		slp <= 1'b1;
		apb(1'b1, 12'h238, 32'h13);
		repeat (3) @(posedge pclk);
		check(det_en, 0);
		slp <= 1'b0;
		apb(1'b1, 12'h240, 32'h3D);
		apb(1'b0, 12'h238, 32'h0);
		check(rd, 32'h13);
		vlow <= 1'b1;
		repeat (15) @(posedge pclk);
		check(core_hold, 1);
		vlow <= 1'b0;
		repeat (1000) @(posedge pclk);
		vlow <= 1'b1;
		repeat (15) @(posedge pclk);
		vlow <= 1'b0;
		wait_run(5100);
		check(cyc > 4980, 1);
		apb(1'b0, 12'h238, 32'h0);
		check(rd & 32'h3, 32'h2);
		n0 = n_load;
		wdt <= 1'b1;
		@(posedge pclk);
		wdt <= 1'b0;
		repeat (2) @(posedge pclk);
		wait_run(50);
		apb(1'b0, 12'h244, 32'h0);
		check(rd[1:0], 2'h2);
		check(n_load - n0, 1);
		hold <= 1'b1;
		repeat (100) @(posedge pclk);
		hold <= 1'b0;
		repeat (250) @(posedge pclk);
		check(core_hold, 0);
		slp <= 1'b1;
		hold <= 1'b1;
		repeat (250) @(posedge pclk);
		check(core_hold, 1);
		hold <= 1'b0;
		wait_run(300);
		apb(1'b0, 12'h244, 32'h0);
		check(rd[1:0], 2'h1);
		check(n_load - n0, 2);
		wdt <= 1'b1;
		@(posedge pclk);
		wdt <= 1'b0;
		repeat (2) @(posedge pclk);
		wait_run(1100);
		slp <= 1'b0;
		apb(1'b0, 12'h244, 32'h0);
		check(rd[1:0], 2'h0);
		check(n_load - n0, 2);
		hold <= 1'b1;
		por <= 1'b1;
		@(posedge pclk);
		por <= 1'b0;
		repeat (5200) @(posedge pclk);
		check(core_hold, 1);
		hold <= 1'b0;
		wait_run(230);
		apb(1'b0, 12'h244, 32'h0);
		check(rd & 32'h3, 32'h3);
		apb(1'b0, 12'h238, 32'h0);
		check(rd[1], 0);
		tally_and_finish();
	end
endmodule : reset_source_sequencer_tb
